/* File: hw/irtmc_top.sv */
// Host controller that programs and steers an infrared transceiver
// Operation
// - Mode programming drives both the transmit pin and power-down pin.
// - Shutdown holds power-down high at least 30 us.
// - Programming pulse lasts at most 5 us, above setup plus rc pulse.
// - Power-down leads programming by 200 ns; 200 ns transmit pulse selects rc.
// - Bandwidth level set 50 ns before latching edge, held 50 ns after.
// - Never drive both transmit pins high while power-down is low.
`timescale 1ns/100ps
`default_nettype none
module irtmc_top (
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic TX_IR_DATA,
  input wire logic TX_RC_DATA,
  output logic POWER_DOWN_INPUT,
  output logic IR_TRANSMIT_INPUT,
  output logic RC_TRANSMIT_INPUT
);
  import irtmc_pkg::*;

  // ****************************************************************
  // Register bus
  // ****************************************************************
  logic [3:0] ctrl_r;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  irtmc_mode_e mode_r;
  irtmc_mode_e target_r;
  irtmc_state_e state_r;
  logic [CNT_W-1:0] cnt_r;
  logic shut_done_r;
  logic sd_r;
  logic ir_r;
  logic rc_r;
  logic wr_en;
  logic rd_setup;
  logic mapped;
  logic prog_go;
  logic busy;

  assign wr_en = PSEL & PENABLE & PWRITE;
  assign rd_setup = PSEL & ~PENABLE & ~PWRITE;
  assign mapped = (PADDR == CTRL_ADDR) | (PADDR == CMD_ADDR) | (PADDR == STATUS_ADDR);
  assign busy = (state_r != IRTMC_ST_IDLE) & (state_r != IRTMC_ST_SHUT);
  // Program only from idle and with no shutdown pending; otherwise dropped
  assign prog_go = wr_en & (PADDR == CMD_ADDR) & PWDATA[CMD_PROGRAM_BIT]
                   & (state_r == IRTMC_ST_IDLE) & ~ctrl_r[CTRL_SHUTDOWN_BIT];

  // Zero-wait slave; answers every access in the access cycle
  assign PREADY = 1'b1;
  assign PRDATA = prdata_r;
  assign PSLVERR = PSEL & PENABLE & ~mapped;

  // Control register
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      ctrl_r <= CTRL_RESET;
    end else if (wr_en && PADDR == CTRL_ADDR) begin
      ctrl_r <= PWDATA[3:0];
    end
  end

  // Read word chosen in the setup cycle; zero outside reads
  always_comb begin
    prdata_nxt = 32'h0;
    if (rd_setup && PADDR == CTRL_ADDR) begin
      prdata_nxt[3:0] = ctrl_r;
    end else if (rd_setup && PADDR == STATUS_ADDR) begin
      prdata_nxt[STAT_BUSY_BIT] = busy;
      prdata_nxt[STAT_SHUT_BIT] = shut_done_r;
      prdata_nxt[STAT_MODE_LSB +: 2] = mode_r;
    end
  end

  // Registered at setup so read data stands through the whole access cycle
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      prdata_r <= 32'h0;
    end else begin
      prdata_r <= prdata_nxt;
    end
  end

  // ****************************************************************
  // Mode sequencer
  // ****************************************************************
  // Each programming step loads the count and leaves when it reaches zero; shutdown holds at zero until released
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      state_r <= IRTMC_ST_IDLE;
      cnt_r <= '0;
    end else begin
      unique case (state_r)
        IRTMC_ST_IDLE: begin
          if (ctrl_r[CTRL_SHUTDOWN_BIT]) begin
            state_r <= IRTMC_ST_SHUT;
            cnt_r <= SHUTDOWN_CNT;
          end else if (prog_go) begin
            state_r <= IRTMC_ST_SETUP;
            cnt_r <= SD_SETUP_CNT;
          end
        end
        IRTMC_ST_SETUP: begin
          if (cnt_r == '0) begin
            state_r <= IRTMC_ST_RCPULSE;
            cnt_r <= RC_PULSE_CNT;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        IRTMC_ST_RCPULSE: begin
          if (cnt_r == '0) begin
            state_r <= IRTMC_ST_BWSETUP;
            cnt_r <= BW_SETUP_CNT;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        IRTMC_ST_BWSETUP: begin
          if (cnt_r == '0) begin
            state_r <= IRTMC_ST_HOLD;
            cnt_r <= HOLD_CNT;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        IRTMC_ST_HOLD: begin
          if (cnt_r == '0) begin
            state_r <= IRTMC_ST_IDLE;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        IRTMC_ST_SHUT: begin
          if (!ctrl_r[CTRL_SHUTDOWN_BIT] && shut_done_r) begin
            state_r <= IRTMC_ST_IDLE;
          end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        default: begin
          state_r <= IRTMC_ST_IDLE;
        end
      endcase
    end
  end

  // Shutdown is only reported once the full width has elapsed
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      shut_done_r <= 1'b0;
    end else if (state_r == IRTMC_ST_SHUT && cnt_r == '0) begin
      shut_done_r <= 1'b1;
    end else if (state_r != IRTMC_ST_SHUT) begin
      shut_done_r <= 1'b0;
    end
  end

  // Target captured at start so a later write cannot alter a sequence
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      target_r <= IRTMC_MODE_SIR;
    end else if (prog_go) begin
      target_r <= irtmc_mode_e'(ctrl_r[CTRL_MODE_LSB +: 2]);
    end
  end

  // Mirror of the mode latched inside the transceiver
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      mode_r <= IRTMC_MODE_SIR;
    end else if (state_r == IRTMC_ST_SHUT && cnt_r == '0) begin
      mode_r <= IRTMC_MODE_SIR;
    end else if (state_r == IRTMC_ST_HOLD && cnt_r == '0) begin
      mode_r <= (target_r == IRTMC_MODE_RSV) ? IRTMC_MODE_SIR : target_r;
    end
  end

  // ****************************************************************
  // Pin drive
  // ****************************************************************
  // Pins are registered so no combinational glitch reaches the LED
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      sd_r <= 1'b0;
      ir_r <= 1'b0;
      rc_r <= 1'b0;
    end else begin
      sd_r <= 1'b0;
      ir_r <= 1'b0;
      rc_r <= 1'b0;
      unique case (state_r)
        IRTMC_ST_SETUP: begin
          sd_r <= 1'b1;
        end
        IRTMC_ST_RCPULSE: begin
          sd_r <= 1'b1;
          ir_r <= (target_r == IRTMC_MODE_RC);
        end
        IRTMC_ST_BWSETUP: begin
          sd_r <= 1'b1;
          ir_r <= (target_r == IRTMC_MODE_FIR);
        end
        IRTMC_ST_HOLD: begin
          ir_r <= (target_r == IRTMC_MODE_FIR);
        end
        IRTMC_ST_SHUT: begin
          sd_r <= 1'b1;
        end
        IRTMC_ST_IDLE: begin
          if (ctrl_r[CTRL_DIRECT_BIT]) begin
            ir_r <= TX_IR_DATA;
            rc_r <= TX_RC_DATA & ~TX_IR_DATA;
          end else if (mode_r == IRTMC_MODE_RC) begin
            ir_r <= TX_RC_DATA;
          end else begin
            ir_r <= TX_IR_DATA;
          end
        end
        default: begin
          sd_r <= 1'b0;
        end
      endcase
    end
  end

  assign POWER_DOWN_INPUT = sd_r;
  assign IR_TRANSMIT_INPUT = ir_r;
  assign RC_TRANSMIT_INPUT = rc_r;
endmodule : irtmc_top
`default_nettype wire

/* File: hw/irtmc_pkg.sv */
// Package of constants for the infrared transceiver mode controller
package irtmc_pkg;
  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_MHZ = 50;
  localparam int T_SHUTDOWN_NS = 30000;     // Least shutdown pulse width
  localparam int T_SD_SETUP_NS = 200;       // Least shutdown setup time
  localparam int T_RC_PULSE_NS = 200;       // Least rc pulse width
  localparam int T_PROG_MAX_NS = 5000;      // Longest programming pulse width
  localparam int T_BW_SETUP_NS = 50;        // Least bandwidth setup time
  localparam int T_HOLD_NS = 50;            // Least mode latch hold time
  // Least times round up, longest times round down
  localparam int SHUTDOWN_CYC = (T_SHUTDOWN_NS * CLK_MHZ + 999) / 1000;
  localparam int SD_SETUP_CYC = (T_SD_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int RC_PULSE_CYC = (T_RC_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int PROG_MAX_CYC = (T_PROG_MAX_NS * CLK_MHZ) / 1000;
  localparam int BW_SETUP_CYC = (T_BW_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_CYC = (T_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] SHUTDOWN_CNT = CNT_W'(SHUTDOWN_CYC - 1);
  localparam logic [CNT_W-1:0] SD_SETUP_CNT = CNT_W'(SD_SETUP_CYC - 1);
  localparam logic [CNT_W-1:0] RC_PULSE_CNT = CNT_W'(RC_PULSE_CYC - 1);
  localparam logic [CNT_W-1:0] BW_SETUP_CNT = CNT_W'(BW_SETUP_CYC - 1);
  localparam logic [CNT_W-1:0] HOLD_CNT = CNT_W'(HOLD_CYC - 1);
  // High time of a programming pulse must stay within the longest width
  localparam int PROG_HIGH_CYC = SD_SETUP_CYC + RC_PULSE_CYC + BW_SETUP_CYC;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] CMD_ADDR = 8'h04;
  localparam logic [7:0] STATUS_ADDR = 8'h08;
  localparam int CTRL_DIRECT_BIT = 0;       // Two-input direct mode
  localparam int CTRL_SHUTDOWN_BIT = 1;     // Request shutdown
  localparam int CTRL_MODE_LSB = 2;         // Target mode, two bits
  localparam int CMD_PROGRAM_BIT = 0;       // Start programming sequence
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_SHUT_BIT = 1;
  localparam int STAT_MODE_LSB = 2;
  localparam logic [3:0] CTRL_RESET = 4'h0;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    IRTMC_MODE_SIR = 2'b00,
    IRTMC_MODE_FIR = 2'b01,
    IRTMC_MODE_RC = 2'b10,
    IRTMC_MODE_RSV = 2'b11
  } irtmc_mode_e;

  typedef enum logic [2:0] {
    IRTMC_ST_IDLE = 3'b000,
    IRTMC_ST_SETUP = 3'b001,
    IRTMC_ST_RCPULSE = 3'b010,
    IRTMC_ST_BWSETUP = 3'b011,
    IRTMC_ST_HOLD = 3'b100,
    IRTMC_ST_SHUT = 3'b101
  } irtmc_state_e;
endpackage : irtmc_pkg

/* File: bench/irtmc_xcvr_model.sv */
// Behavioural model of the transceiver mode latch and LED
`timescale 1ns/100ps
`default_nettype none
module irtmc_xcvr_model import irtmc_pkg::*; (
  input wire logic clk,
  input wire logic sd,
  input wire logic ir,
  input wire logic rc,
  output logic led,
  output logic [1:0] mode
);
  int hi;
  int irhi;
  // Power-up default
  initial mode = IRTMC_MODE_SIR;
  // With power-down low, one input high lights the LED; both high leaves it dark
  assign led = !sd && (ir ^ rc);
  // Widths timed in bench cycles; the real part has no clock
  always @(posedge clk) begin
    if (sd) begin
      hi <= hi + 1;
      irhi <= irhi + int'(ir);
    end else begin
      if (hi >= 1500) mode <= IRTMC_MODE_SIR;
      else if (hi > 0 && hi <= 250) mode <= irhi >= 10 ? IRTMC_MODE_RC :
        ir ? IRTMC_MODE_FIR : IRTMC_MODE_SIR;
      hi <= 0;
      irhi <= 0;
    end
  end
endmodule : irtmc_xcvr_model
`default_nettype wire

/* File: bench/irtmc_top_sva.sv */
// Checker of pin timing for the transceiver controller
`timescale 1ns/100ps
`default_nettype none
module irtmc_top_sva import irtmc_pkg::*; (
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic TX_IR_DATA,
  input wire logic TX_RC_DATA,
  input wire logic POWER_DOWN_INPUT,
  input wire logic IR_TRANSMIT_INPUT,
  input wire logic RC_TRANSMIT_INPUT
);
  logic sd, ir, rc, direct_r;
  logic [11:0] hi_r, lo_r;
  assign sd = POWER_DOWN_INPUT;
  assign ir = IR_TRANSMIT_INPUT;
  assign rc = RC_TRANSMIT_INPUT;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  // Run lengths of power-down high and low, saturating
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N || !sd) hi_r <= 12'h000;
    else if (hi_r != 12'hFFF) hi_r <= hi_r + 12'h001;
  end
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N || sd) lo_r <= 12'h000;
    else if (lo_r != 12'hFFF) lo_r <= lo_r + 12'h001;
  end
  // Direct-mode shadow taken from bus writes
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) direct_r <= 1'b0;
    else if (PSEL && PENABLE && PWRITE && PADDR == CTRL_ADDR) direct_r <= PWDATA[0];
  end
  no_both_tx_a: assert property (!sd |-> !(ir && rc)) else $error("both tx high");
  sd_width_a: assert property ($fell(sd) |-> (hi_r > SD_SETUP_CYC + RC_PULSE_CYC &&
    hi_r <= PROG_MAX_CYC) || hi_r >= SHUTDOWN_CYC) else $error("bad power-down width");
  sd_setup_a: assert property (sd && $rose(ir) |-> hi_r >= 10) else $error("short setup");
  rc_pulse_a: assert property (sd && $fell(ir) && hi_r > 10 |-> $past(ir, 10))
    else $error("short rc pulse");
  rc_quiet_a: assert property (sd |-> !rc) else $error("rc pin during power-down");
  shut_dark_a: assert property (sd && hi_r > PROG_MAX_CYC |-> !ir && !rc)
    else $error("LED driven in shutdown");
  latch_hold_a: assert property ($fell(sd) && hi_r < 300 |-> $stable(ir)[*3])
    else $error("latch hold broken");
  bw_setup_a: assert property ($fell(sd) && hi_r < 300 |-> $past(ir, 1) == $past(ir, 3) &&
    $past(ir, 2) == $past(ir, 3)) else $error("bandwidth setup broken");
  direct_steer_a: assert property ($past(direct_r) && !sd && lo_r > 6 |->
    ir == $past(TX_IR_DATA) && rc == ($past(TX_RC_DATA) && !$past(TX_IR_DATA)))
    else $error("direct steering wrong");
  single_rc_a: assert property (!$past(direct_r) && !sd && lo_r > 6 |-> !rc)
    else $error("rc pin in single mode");
  cover property ($fell(sd) && hi_r == 23);
  cover property ($fell(sd) && hi_r >= 1500);
  cover property (direct_r && rc);
endmodule : irtmc_top_sva
`default_nettype wire

/* File: bench/tb_irtmc_top.sv */
// Self-checking bench for the transceiver controller
`timescale 1ns/100ps
`default_nettype none
module tb_irtmc_top;
  import irtmc_pkg::*;
  logic SYS_CLK = 1'b0;
  logic RESET_N = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic TX_IR_DATA = 1'b0;
  logic TX_RC_DATA = 1'b0;
  logic [31:0] PRDATA, q;
  logic PREADY, PSLVERR, POWER_DOWN_INPUT, IR_TRANSMIT_INPUT, RC_TRANSMIT_INPUT, led, err;
  logic [1:0] mode;
  int fails = 0;
  int n_compared = 0;
  always #10 SYS_CLK = ~SYS_CLK;
  irtmc_top i_irtmc_top (.SYS_CLK, .RESET_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
    .PRDATA, .PREADY, .PSLVERR, .TX_IR_DATA, .TX_RC_DATA, .POWER_DOWN_INPUT,
    .IR_TRANSMIT_INPUT, .RC_TRANSMIT_INPUT);
  irtmc_xcvr_model i_irtmc_xcvr_model (.clk(SYS_CLK), .sd(POWER_DOWN_INPUT),
    .ir(IR_TRANSMIT_INPUT), .rc(RC_TRANSMIT_INPUT), .led(led), .mode(mode));
  task check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task summarize;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  // One APB transfer; waits for ready, no latency assumed
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    do @(posedge SYS_CLK); while (PREADY !== 1'b1);
    q = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb
  task t_reset;
    apb(1'b0, CTRL_ADDR, 32'h0);
    check(q, {28'h0, CTRL_RESET});
    check({31'h0, PREADY}, 32'h1);
    apb(1'b0, STATUS_ADDR, 32'h0);
    check(q, 32'h0);
    check({30'h0, mode}, {30'h0, IRTMC_MODE_SIR});
    apb(1'b0, 8'h0C, 32'h0);
    check(q, 32'h0);
    check({31'h0, err}, 32'h1);
  endtask : t_reset
  // Program a target, a second command lands while busy
  task t_prog(input logic [1:0] tgt, input logic [1:0] exp);
    apb(1'b1, CTRL_ADDR, {28'h0, tgt, 2'b00});
    apb(1'b1, CMD_ADDR, 32'h1);
    apb(1'b1, CMD_ADDR, 32'h1);
    apb(1'b0, STATUS_ADDR, 32'h0);
    check({31'h0, q[STAT_BUSY_BIT]}, 32'h1);
    for (int i = 0; i < 50; i++) begin
      apb(1'b0, STATUS_ADDR, 32'h0);
      if (q[STAT_BUSY_BIT] === 1'b0) break;
    end
    check({31'h0, q[STAT_BUSY_BIT]}, 32'h0);
    check({30'h0, q[STAT_MODE_LSB +: 2]}, {30'h0, exp});
    check({30'h0, mode}, {30'h0, exp});
  endtask : t_prog
  task t_steer(input logic ird, rcd, eir, erc);
    @(posedge SYS_CLK);
    TX_IR_DATA <= ird;
    TX_RC_DATA <= rcd;
    repeat (3) @(posedge SYS_CLK);
    #1;
    check({30'h0, IR_TRANSMIT_INPUT, RC_TRANSMIT_INPUT}, {30'h0, eir, erc});
    check({31'h0, led}, {31'h0, eir | erc});
  endtask : t_steer
  // Early release of the request must not shorten power-down
  task t_shut;
    int n;
    n = 0;
    apb(1'b1, CTRL_ADDR, 32'h2);
    repeat (100) @(posedge SYS_CLK);
    apb(1'b1, CTRL_ADDR, 32'h0);
    #1;
    check({31'h0, POWER_DOWN_INPUT}, 32'h1);
    while (POWER_DOWN_INPUT === 1'b1 && n < 2000) begin
      @(posedge SYS_CLK);
      n++;
    end
    check({31'h0, n + 100 >= SHUTDOWN_CYC && n + 100 <= SHUTDOWN_CYC + 4}, 32'h1);
    apb(1'b0, STATUS_ADDR, 32'h0);
    check({30'h0, q[STAT_MODE_LSB +: 2]}, {30'h0, IRTMC_MODE_SIR});
    check({30'h0, mode}, {30'h0, IRTMC_MODE_SIR});
  endtask : t_shut
  // Held request completes power-down; programming is refused meanwhile
  task t_shut_hold;
    apb(1'b1, CTRL_ADDR, 32'h2);
    apb(1'b1, CMD_ADDR, 32'h1);
    repeat (SHUTDOWN_CYC) @(posedge SYS_CLK);
    apb(1'b0, STATUS_ADDR, 32'h0);
    check(q, 32'h2);
    check({31'h0, POWER_DOWN_INPUT}, 32'h1);
    apb(1'b1, CTRL_ADDR, 32'h0);
    repeat (3) @(posedge SYS_CLK);
    #1;
    check({31'h0, POWER_DOWN_INPUT}, 32'h0);
    check({30'h0, mode}, {30'h0, IRTMC_MODE_SIR});
  endtask : t_shut_hold
  task t_direct;
    apb(1'b1, CTRL_ADDR, 32'h1);
    t_steer(1'b0, 1'b0, 1'b0, 1'b0);
    t_steer(1'b0, 1'b1, 1'b0, 1'b1);
    t_steer(1'b1, 1'b0, 1'b1, 1'b0);
    t_steer(1'b1, 1'b1, 1'b1, 1'b0);
  endtask : t_direct
  initial begin
    repeat (16) @(posedge SYS_CLK);
    RESET_N <= 1'b1;
    t_reset;
    t_prog(IRTMC_MODE_FIR, IRTMC_MODE_FIR);
    t_prog(IRTMC_MODE_RSV, IRTMC_MODE_SIR);
    t_prog(IRTMC_MODE_RC, IRTMC_MODE_RC);
    t_steer(1'b0, 1'b1, 1'b1, 1'b0);
    t_steer(1'b1, 1'b0, 1'b0, 1'b0);
    t_steer(1'b0, 1'b0, 1'b0, 1'b0);
    t_shut;
    t_steer(1'b1, 1'b0, 1'b1, 1'b0);
    t_steer(1'b0, 1'b1, 1'b0, 1'b0);
    t_shut_hold;
    t_direct;
    summarize;
  end
  // Whole run is a few thousand cycles
  initial begin
    #400000;
    fails++;
    summarize;
  end
endmodule : tb_irtmc_top
bind irtmc_top irtmc_top_sva i_irtmc_top_sva (.SYS_CLK, .RESET_N, .PSEL, .PENABLE, .PWRITE,
  .PADDR, .PWDATA, .TX_IR_DATA, .TX_RC_DATA, .POWER_DOWN_INPUT, .IR_TRANSMIT_INPUT,
  .RC_TRANSMIT_INPUT);
`default_nettype wire
